// >>> scd_divider.sv
// sample clock divider with sync realignment and duty cycle retimer
`timescale 1ns/1ps
`default_nettype none
module scd_divider
  import scd_pkg::*;
#(
  parameter int PER_W = 8
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  // sample clock and sync pulse from the far side
  input  wire logic               sample_clk_in,
  input  wire logic               sync_in,
  // control
  input  wire logic [RATIO_W-1:0] div_ratio,
  input  wire logic [1:0]         sync_mode,
  input  wire logic               sync_mode_wr,
  input  wire logic               pin_mode,
  input  wire logic               duty_cycle_retimer,
  input  wire logic               serial_io_retimer_strap,
  // conversion clock and status
  output logic                    conv_clk,
  output logic                    sample_strobe,
  output logic                    retimer_active,
  output logic                    sync_armed
);
  logic               clk_q;
  logic               sync_q;
  logic [RATIO_W-1:0] div_count;
  logic [PER_W-1:0]   since_rise;
  logic [PER_W-1:0]   period;
  logic               strap_done;
  logic               strap_level;
  logic [RATIO_W-1:0] ratio_m1;
  logic               clk_rise;
  logic               clk_fall;
  logic               sync_rise;
  logic               valid_sync;
  logic               samp_edge;
  logic               retimer_en;
  logic [PER_W-1:0]   elapsed;

  // out-of-range ratios are clamped rather than left to wrap oddly
  always_comb begin
    if (div_ratio < RATIO_MIN)
      ratio_m1 = '0;
    else if (div_ratio > RATIO_MAX)
      ratio_m1 = RATIO_MAX - RATIO_MIN;
    else
      ratio_m1 = div_ratio - RATIO_MIN;
  end

  assign clk_rise   = sample_clk_in & ~clk_q;
  assign clk_fall   = ~sample_clk_in & clk_q;
  assign sync_rise  = sync_in & ~sync_q;
  assign valid_sync = sync_rise & sync_mode[SYNC_EN_BIT]
                    & (~sync_mode[SYNC_FIRST_BIT] | sync_armed);
  // sync in the same cycle as an input edge wins; that edge is not a sample
  assign samp_edge  = clk_rise & (div_count == '0) & ~valid_sync;
  assign retimer_en = pin_mode ? strap_level : duty_cycle_retimer;
  assign elapsed    = since_rise + PER_W'(1);

  // high time ends at half the measured period; an odd period rounds it down
  function automatic logic half_reached(input logic [PER_W-1:0] el,
                                        input logic [PER_W-1:0] per);
    return el >= (per >> 1);
  endfunction : half_reached

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clk_q  <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      clk_q  <= sample_clk_in;
      sync_q <= sync_in;
    end
  end

  // strap level is caught on the first edge after reset release
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      strap_done <= 1'b0;
      strap_level <= RETIMER_STRAP_RST;
    end else if (!strap_done) begin
      strap_done  <= 1'b1;
      strap_level <= serial_io_retimer_strap;
    end
  end

  // a write arms; when both land together the write wins so no re-arm is lost
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      sync_armed <= 1'b0;
    else if (sync_mode_wr)
      sync_armed <= 1'b1;
    else if (valid_sync)
      sync_armed <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      div_count <= '0;
    else if (valid_sync)
      div_count <= '0;
    else if (clk_rise)
      div_count <= (div_count == ratio_m1) ? '0 : div_count + RATIO_W'(1);
  end

  // period of the divided clock in sys_clk cycles; the counter saturates and an overlong period reads as zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      since_rise <= '0;
      period     <= '0;
    end else if (samp_edge) begin
      since_rise <= '0;
      period     <= elapsed;
    end else if (since_rise != '1) begin
      since_rise <= elapsed;
    end
  end

  // too slow a clock leaves the loop unlocked and the input edge is used
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      retimer_active <= 1'b0;
    else
      retimer_active <= retimer_en && period != '0
                        && period <= PER_W'(RETIMER_MAX_CYC);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      conv_clk <= 1'b0;
    else if (valid_sync)
      conv_clk <= 1'b0;
    else if (samp_edge)
      conv_clk <= 1'b1;
    else if (retimer_active ? half_reached(elapsed, period) : clk_fall)
      conv_clk <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      sample_strobe <= 1'b0;
    else
      sample_strobe <= samp_edge;
  end

  sample_edge_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    samp_edge |=> conv_clk && sample_strobe)
    else $error("sample edge did not raise conversion clock");

  strobe_pulse_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    sample_strobe |=> !sample_strobe)
    else $error("sample strobe longer than one cycle");

  sync_realign_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    valid_sync |=> div_count == '0 && !conv_clk && !sample_strobe)
    else $error("sync did not reset divider");

  div_wrap_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_rise && !valid_sync && div_count == ratio_m1 |=> div_count == '0)
    else $error("divider did not wrap at ratio");

  div_step_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_rise && !valid_sync && div_count != ratio_m1
    |=> div_count == $past(div_count) + RATIO_W'(1))
    else $error("divider did not advance on input edge");

  first_arm_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    sync_mode_wr |=> sync_armed)
    else $error("field write did not arm sync");

  first_only_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    sync_mode[SYNC_FIRST_BIT] && !sync_armed && sync_rise |-> !valid_sync)
    else $error("unarmed sync accepted in first-only mode");

  slow_clock_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    period > PER_W'(RETIMER_MAX_CYC) |=> !retimer_active)
    else $error("retimer active below minimum rate");

  half_fall_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    retimer_active && conv_clk && !samp_edge && !valid_sync
    && half_reached(elapsed, period) |=> !conv_clk)
    else $error("retimed fall missed half period");

  strap_take_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !strap_done |=> strap_level == $past(serial_io_retimer_strap))
    else $error("strap level not captured");

  strap_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    strap_done |=> $stable(strap_level))
    else $error("strap level changed after capture");

  retimer_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !retimer_en |=> !retimer_active)
    else $error("retimer active while disabled");

  lock_range_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    retimer_en && period != '0 && period <= PER_W'(RETIMER_MAX_CYC) |=> retimer_active)
    else $error("retimer not locked at a fast enough clock");

  input_fall_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !retimer_active && conv_clk && clk_fall && !valid_sync |=> !conv_clk)
    else $error("conversion clock missed input fall");

  rise_only_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !conv_clk && !samp_edge |=> !conv_clk)
    else $error("conversion clock rose without a sample edge");

  skip_rise_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_rise && div_count != '0 |=> !sample_strobe)
    else $error("sample taken off the divided edge");

  sync_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    sync_rise && !sync_mode[SYNC_EN_BIT] && !clk_rise |=> div_count == $past(div_count))
    else $error("disabled sync moved the divider");

  armed_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    sync_armed && !valid_sync |=> sync_armed)
    else $error("armed state lost without a sync");
endmodule : scd_divider
`default_nettype wire

// >>> scd_pkg.sv
// constants for the sample clock divider and sync logic
package scd_pkg;
  localparam int          SYS_CLK_MHZ    = 200;
  localparam int          RETIMER_MIN_MHZ = 20;
  // longest divided period, in sys_clk cycles, that the retimer still tracks
  localparam int          RETIMER_MAX_CYC = SYS_CLK_MHZ / RETIMER_MIN_MHZ;
  localparam int          RATIO_W        = 3;
  localparam logic [2:0]  RATIO_MIN      = 3'h1;
  localparam logic [2:0]  RATIO_MAX      = 3'h6;
  localparam int          SYNC_EN_BIT    = 0;
  localparam int          SYNC_FIRST_BIT = 1;
  localparam logic        RETIMER_STRAP_RST = 1'b1;
endpackage : scd_pkg

// >>> scd_clk_src.sv
// far-side model: sample clock source and sync pulse driver
`timescale 1ns/1ps
`default_nettype none
module scd_clk_src (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // clock shape in sys_clk cycles
  input  wire logic       run,
  input  wire logic [4:0] hi_cyc,
  input  wire logic [4:0] lo_cyc,
  // to the divider
  output logic            sample_clk_in,
  output logic            sync_in
);
  logic [4:0] cnt;
  initial sync_in = 1'b0;
  // clock stands low between bursts so no stray rise steps the divider
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sample_clk_in <= 1'b0;
      cnt           <= 5'h1;
    end else if (!run) begin
      sample_clk_in <= 1'b0;
      cnt           <= 5'h1;
    end else if (cnt > 5'h1) begin
      cnt <= cnt - 5'h1;
    end else begin
      sample_clk_in <= !sample_clk_in;
      cnt           <= sample_clk_in ? lo_cyc : hi_cyc;
    end
  end
  task automatic pulse_sync();
    @(posedge sys_clk) sync_in <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sync_in <= 1'b0;
  endtask : pulse_sync
endmodule : scd_clk_src
`default_nettype wire

// >>> scd_divider_tb.sv
// self-checking bench for the sample clock divider
`timescale 1ns/1ps
`default_nettype none
module scd_divider_tb;
  import scd_pkg::*;
  logic       sys_clk, resetn, run, sample_clk_in, sync_in, sync_mode_wr, pin_mode;
  logic       duty_cycle_retimer, serial_io_retimer_strap;
  logic       conv_clk, sample_strobe, retimer_active, sync_armed;
  logic [2:0] div_ratio;
  logic [1:0] sync_mode;
  logic [4:0] hi_cyc, lo_cyc;
  int         n_fail, samples_checked, n_str, n_hi;
  // 5 us at a 5 ns clock: the longest relock wait after a rate change
  localparam int RELOCK_CYC = 1000;
  // ratio beside expected samples in 12 input rises
  logic [6:0] rows [8] = '{7'h0c, 7'h1c, 7'h26, 7'h34, 7'h43, 7'h53, 7'h62, 7'h72};
  scd_divider u_scd_divider (.sys_clk(sys_clk), .resetn(resetn),
    .sample_clk_in(sample_clk_in), .sync_in(sync_in), .div_ratio(div_ratio),
    .sync_mode(sync_mode), .sync_mode_wr(sync_mode_wr), .pin_mode(pin_mode),
    .duty_cycle_retimer(duty_cycle_retimer),
    .serial_io_retimer_strap(serial_io_retimer_strap), .conv_clk(conv_clk),
    .sample_strobe(sample_strobe), .retimer_active(retimer_active),
    .sync_armed(sync_armed));
  scd_clk_src u_scd_clk_src (.sys_clk(sys_clk), .resetn(resetn), .run(run),
    .hi_cyc(hi_cyc), .lo_cyc(lo_cyc), .sample_clk_in(sample_clk_in), .sync_in(sync_in));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // counted on the falling edge so the counters never race their posedge clears
  always @(negedge sys_clk) begin
    n_str += (sample_strobe === 1'b1);
    n_hi  += (conv_clk === 1'b1);
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checks=%0d fails=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic burst(input int rises);
    n_str = 0;
    run <= 1'b1;
    repeat (rises * 4) @(posedge sys_clk);
    run <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : burst
  task automatic settle(input logic [4:0] hi, input logic [4:0] lo);
    hi_cyc <= hi;
    lo_cyc <= lo;
    repeat (RELOCK_CYC) @(posedge sys_clk);
    n_hi = 0;
    repeat (24) @(posedge sys_clk);
  endtask : settle
  initial begin
    resetn = 1'b0;
    run = 1'b0;
    hi_cyc = 5'h2;
    lo_cyc = 5'h2;
    div_ratio = 3'h1;
    sync_mode = 2'h1;
    sync_mode_wr = 1'b0;
    pin_mode = 1'b0;
    duty_cycle_retimer = 1'b0;
    serial_io_retimer_strap = 1'b1;
    repeat (10) @(posedge sys_clk);
    check(8'({conv_clk, sample_strobe, retimer_active, sync_armed}), 8'h0);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      div_ratio <= rows[i][6:4];
      duty_cycle_retimer <= !(rows[i][6:4] inside {3'h0, 3'h1, 3'h2, 3'h4});
      u_scd_clk_src.pulse_sync();
      burst(12);
      check(8'(n_str), 8'(rows[i][3:0]));
    end
    div_ratio <= 3'h2;
    u_scd_clk_src.pulse_sync();
    burst(1);
    sync_mode <= 2'h0;
    u_scd_clk_src.pulse_sync();
    burst(1);
    check(8'(n_str), 8'h0);
    sync_mode <= 2'h3;
    sync_mode_wr <= 1'b1;
    @(posedge sys_clk) sync_mode_wr <= 1'b0;
    @(negedge sys_clk) check(8'(sync_armed), 8'h1);
    u_scd_clk_src.pulse_sync();
    check(8'(sync_armed), 8'h0);
    burst(1);
    u_scd_clk_src.pulse_sync();
    burst(1);
    check(8'(n_str), 8'h0);
    div_ratio <= 3'h1;
    duty_cycle_retimer <= 1'b1;
    run <= 1'b1;
    settle(5'h1, 5'h5);
    check(8'(retimer_active), 8'h1);
    check(8'(n_hi), 8'h0c);
    duty_cycle_retimer <= 1'b0;
    settle(5'h1, 5'h5);
    check(8'(n_hi), 8'h4);
    pin_mode <= 1'b1;
    settle(5'h1, 5'h5);
    check(8'(retimer_active), 8'h1);
    settle(5'ha, 5'ha);
    check(8'(retimer_active), 8'h0);
    // second reset with the strap tied low: strap mode must keep the retimer off
    resetn <= 1'b0;
    serial_io_retimer_strap <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(8'({conv_clk, sample_strobe, retimer_active, sync_armed}), 8'h0);
    resetn <= 1'b1;
    settle(5'h1, 5'h5);
    check(8'(retimer_active), 8'h0);
    check(8'(n_hi), 8'h4);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    test_done();
  end
endmodule : scd_divider_tb
`default_nettype wire
